// ==== shared/ebr_pkg.sv ====
// Constants, types and helper functions shared by the embedded block RAM design.
package ebr_pkg;

  localparam int unsigned EBR_MEM_BITS = 10240;
  localparam int unsigned EBR_BIT_AW = 14;
  localparam int unsigned EBR_AW = 13;
  localparam int unsigned EBR_DW = 20;
  localparam int unsigned EBR_BEW = 2;
  localparam int unsigned EBR_PTR_W = 9;
  localparam int unsigned EBR_RAW = 4;
  localparam int unsigned EBR_RDW = 32;

  typedef enum logic [1:0] {
    EBR_SINGLE    = 2'b00,
    EBR_SIMPLE_DP = 2'b01,
    EBR_TRUE_DP   = 2'b10,
    EBR_ROM       = 2'b11
  } ebr_mode_e;

  typedef enum logic [2:0] {
    EBR_G1024X8  = 3'b000,
    EBR_G2048X4  = 3'b001,
    EBR_G4096X2  = 3'b010,
    EBR_G8192X1  = 3'b011,
    EBR_G1024X10 = 3'b100,
    EBR_G2048X5  = 3'b101,
    EBR_G512X16  = 3'b110,
    EBR_G512X20  = 3'b111
  } ebr_geom_e;

  // Register byte offsets.
  localparam logic [EBR_RAW-1:0] EBR_REG_CFG = 4'h0;
  localparam logic [EBR_RAW-1:0] EBR_REG_INIT_ADDR = 4'h4;
  localparam logic [EBR_RAW-1:0] EBR_REG_INIT_DATA = 4'h8;
  localparam logic [EBR_RAW-1:0] EBR_REG_STATUS = 4'hc;

  // Configuration and status field positions.
  localparam int unsigned EBR_CFG_MODE_LSB = 0;
  localparam int unsigned EBR_CFG_GA_LSB = 2;
  localparam int unsigned EBR_CFG_GB_LSB = 5;
  localparam int unsigned EBR_CFG_OREG_A = 8;
  localparam int unsigned EBR_CFG_OREG_B = 9;
  localparam int unsigned EBR_CFG_W = 10;
  localparam int unsigned EBR_ST_COLL = 0;
  localparam int unsigned EBR_ST_ROMWR = 1;
  localparam int unsigned EBR_ST_W = 2;

  localparam ebr_mode_e EBR_MODE_RST = EBR_SINGLE;
  localparam ebr_geom_e EBR_GEOM_RST = EBR_G1024X8;
  localparam logic [EBR_PTR_W-1:0] EBR_PTR_RST = 9'h000;
  localparam logic [EBR_DW-1:0] EBR_DATA_RST = 20'h0_0000;
  localparam logic [EBR_AW-1:0] EBR_ADDR_RST = 13'h0000;

  function automatic logic [4:0] ebr_width(input ebr_geom_e g);
    logic [4:0] w;
    w = 5'h08;
    unique case (g)
      EBR_G1024X8: w = 5'h08;
      EBR_G2048X4: w = 5'h04;
      EBR_G4096X2: w = 5'h02;
      EBR_G8192X1: w = 5'h01;
      EBR_G1024X10: w = 5'h0a;
      EBR_G2048X5: w = 5'h05;
      EBR_G512X16: w = 5'h10;
      EBR_G512X20: w = 5'h14;
    endcase
    return w;
  endfunction

  function automatic logic [EBR_AW-1:0] ebr_mask(input ebr_geom_e g);
    logic [EBR_AW-1:0] m;
    m = 13'h03ff;
    unique case (g)
      EBR_G1024X8, EBR_G1024X10: m = 13'h03ff;
      EBR_G2048X4, EBR_G2048X5: m = 13'h07ff;
      EBR_G4096X2: m = 13'h0fff;
      EBR_G8192X1: m = 13'h1fff;
      EBR_G512X16, EBR_G512X20: m = 13'h01ff;
    endcase
    return m;
  endfunction

  // First bit of the addressed word; address bits above the depth are ignored.
  function automatic logic [EBR_BIT_AW-1:0] ebr_base(input logic [EBR_AW-1:0] a,
                                                     input ebr_geom_e g);
    logic [18:0] p;
    p = 19'(a & ebr_mask(g)) * 19'(ebr_width(g));
    return p[EBR_BIT_AW-1:0];
  endfunction

  // Wide words split into two lanes of 8 or 10 bits; narrow words are one lane.
  function automatic logic [4:0] ebr_lane_w(input ebr_geom_e g);
    logic [4:0] w;
    w = ebr_width(g);
    if (g == EBR_G512X16 || g == EBR_G512X20) begin
      w = {1'b0, w[4:1]};
    end
    return w;
  endfunction

endpackage

// ==== design/ebr_port.sv ====
// One memory port: address capture register and read data output stage.
module ebr_port
  import ebr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic addr_en,
  input wire logic [EBR_AW-1:0] addr,
  input wire logic oreg_en,
  input wire logic out_rst,
  input wire logic [EBR_DW-1:0] rd_word,
  output logic [EBR_AW-1:0] addr_eff,
  output logic [EBR_DW-1:0] rdata
);

  logic [EBR_AW-1:0] addr_q;
  logic [EBR_DW-1:0] pipe_q;
  logic [EBR_DW-1:0] rdata_q;

  // The live address is used in the cycle it is enabled, so the array sees it without delay.
  assign addr_eff = addr_en ? addr : addr_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_q <= EBR_ADDR_RST;
    end else if (ce && addr_en) begin
      addr_q <= addr;
    end
  end

  // The output reset only touches this stage; the array is never cleared by it.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pipe_q <= EBR_DATA_RST;
      rdata_q <= EBR_DATA_RST;
    end else if (ce) begin
      if (out_rst) begin
        pipe_q <= EBR_DATA_RST;
        rdata_q <= EBR_DATA_RST;
      end else begin
        pipe_q <= rd_word;
        rdata_q <= oreg_en ? pipe_q : rd_word;
      end
    end
  end

  assign rdata = rdata_q;

endmodule

// ==== design/ebr_block.sv ====
// Embedded block RAM: 10-kbit array, two configurable ports and a configuration register port.
// Operation
// - The array holds 10240 bits and every port access happens on the rising clock edge.
// - Software selects single-port, simple dual-port, true dual-port or read-only operation.
// - A content image can be loaded before use and read back at once, in read-only mode too.
// - The write-side port and the read-side port each take their own geometry.
// - Each port holds its last captured address while its address enable is low.
// - Each port's output reset clears its output stage and leaves the array alone.
// - In simple dual-port mode byte enables pick which lanes of the word are written.
// - In true dual-port mode each port offers 1024x8, 2048x4, 4096x2, 8192x1, 1024x10, 2048x5.
//
// The strobed register port and the register addresses were left to the implementer.
module ebr_block
  import ebr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [EBR_RAW-1:0] reg_addr,
  input wire logic [EBR_RDW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [EBR_RDW-1:0] reg_rdata,
  input wire logic a_addr_en,
  input wire logic [EBR_AW-1:0] a_addr,
  input wire logic a_we,
  input wire logic [EBR_DW-1:0] a_wdata,
  input wire logic [EBR_BEW-1:0] a_be,
  input wire logic a_out_rst,
  output logic [EBR_DW-1:0] a_rdata,
  input wire logic b_addr_en,
  input wire logic [EBR_AW-1:0] b_addr,
  input wire logic b_we,
  input wire logic [EBR_DW-1:0] b_wdata,
  input wire logic b_out_rst,
  output logic [EBR_DW-1:0] b_rdata
);

  // No reset on the array: unloaded contents are arbitrary, as in the real macro.
  logic [EBR_MEM_BITS-1:0] mem_q;
  ebr_mode_e mode_q;
  ebr_geom_e geom_a_q;
  ebr_geom_e geom_b_q;
  logic oreg_a_q;
  logic oreg_b_q;
  logic [EBR_PTR_W-1:0] ptr_q;
  logic coll_q;
  logic romwr_q;
  logic [EBR_RDW-1:0] reg_rdata_q;

  logic [EBR_AW-1:0] a_addr_eff;
  logic [EBR_AW-1:0] b_addr_eff;
  logic [EBR_BIT_AW-1:0] a_base;
  logic [EBR_BIT_AW-1:0] b_base;
  logic [EBR_BIT_AW-1:0] init_base;
  logic [4:0] a_w;
  logic [4:0] b_w;
  logic [4:0] a_lane;
  logic [EBR_DW-1:0] a_word;
  logic [EBR_DW-1:0] b_word;
  logic [EBR_DW-1:0] init_word;
  logic a_rd_ok;
  logic b_rd_ok;
  logic a_wr_ok;
  logic b_wr_ok;
  logic init_wr;
  logic coll_set;
  logic romwr_set;
  logic [EBR_CFG_W-1:0] cfg_word;

  // Gathers one word of up to 20 bits starting at base; unused upper bits read as zero.
  function automatic logic [EBR_DW-1:0] fetch(input logic [EBR_MEM_BITS-1:0] m,
                                              input logic [EBR_BIT_AW-1:0] base,
                                              input logic [4:0] w);
    logic [EBR_DW-1:0] d;
    logic [EBR_BIT_AW-1:0] idx;
    d = EBR_DATA_RST;
    for (int i = 0; i < EBR_DW; i++) begin
      idx = base + EBR_BIT_AW'(i);
      if (5'(i) < w) begin
        d[i] = m[idx];
      end
    end
    return d;
  endfunction

  // Wide geometries fall back to 1024x8 outside simple dual-port mode.
  function automatic ebr_geom_e legal_geom(input logic [2:0] g, input logic [1:0] m);
    ebr_geom_e r;
    r = ebr_geom_e'(g);
    if (ebr_mode_e'(m) != EBR_SIMPLE_DP && (r == EBR_G512X16 || r == EBR_G512X20)) begin
      r = EBR_GEOM_RST;
    end
    return r;
  endfunction

  assign a_w = ebr_width(geom_a_q);
  assign b_w = ebr_width(geom_b_q);
  assign a_lane = ebr_lane_w(geom_a_q);
  assign a_base = ebr_base(a_addr_eff, geom_a_q);
  assign b_base = ebr_base(b_addr_eff, geom_b_q);
  assign init_base = ebr_base({4'h0, ptr_q}, EBR_G512X20);

  // Port A is the write side in simple dual-port mode; port B is idle in single-port mode.
  assign a_rd_ok = (mode_q != EBR_SIMPLE_DP);
  assign b_rd_ok = (mode_q != EBR_SINGLE);
  assign a_wr_ok = a_we && (mode_q != EBR_ROM);
  assign b_wr_ok = b_we && (mode_q == EBR_TRUE_DP);
  assign init_wr = reg_wr && (reg_addr == EBR_REG_INIT_DATA);

  assign a_word = a_rd_ok ? fetch(mem_q, a_base, a_w) : EBR_DATA_RST;
  assign b_word = b_rd_ok ? fetch(mem_q, b_base, b_w) : EBR_DATA_RST;
  assign init_word = fetch(mem_q, init_base, ebr_width(EBR_G512X20));

  // Overlap test on bit ranges, since the two ports may use different widths.
  assign coll_set = a_wr_ok && b_wr_ok && !init_wr &&
                    (a_base < b_base + EBR_BIT_AW'(b_w)) &&
                    (b_base < a_base + EBR_BIT_AW'(a_w));
  assign romwr_set = (a_we || b_we) && (mode_q == EBR_ROM);

  assign cfg_word = {oreg_b_q, oreg_a_q, geom_b_q, geom_a_q, mode_q};

  ebr_port u_port_a (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .addr_en(a_addr_en),
    .addr(a_addr),
    .oreg_en(oreg_a_q),
    .out_rst(a_out_rst),
    .rd_word(a_word),
    .addr_eff(a_addr_eff),
    .rdata(a_rdata)
  );

  ebr_port u_port_b (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .addr_en(b_addr_en),
    .addr(b_addr),
    .oreg_en(oreg_b_q),
    .out_rst(b_out_rst),
    .rd_word(b_word),
    .addr_eff(b_addr_eff),
    .rdata(b_rdata)
  );

  // Array writes. An image load takes the whole cycle; port B is written last, so it
  // prevails when both ports hit the same bit.
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (init_wr) begin
        for (int i = 0; i < EBR_DW; i++) begin
          mem_q[init_base + EBR_BIT_AW'(i)] <= reg_wdata[i];
        end
      end else begin
        if (a_wr_ok) begin
          for (int i = 0; i < EBR_DW; i++) begin
            if (5'(i) < a_w &&
                (mode_q != EBR_SIMPLE_DP || a_be[(5'(i) >= a_lane) ? 1 : 0])) begin
              mem_q[a_base + EBR_BIT_AW'(i)] <= a_wdata[i];
            end
          end
        end
        if (b_wr_ok) begin
          for (int i = 0; i < EBR_DW; i++) begin
            if (5'(i) < b_w) begin
              mem_q[b_base + EBR_BIT_AW'(i)] <= b_wdata[i];
            end
          end
        end
      end
    end
  end

  // Configuration register.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_q <= EBR_MODE_RST;
      geom_a_q <= EBR_GEOM_RST;
      geom_b_q <= EBR_GEOM_RST;
      oreg_a_q <= 1'b0;
      oreg_b_q <= 1'b0;
    end else if (ce && reg_wr && reg_addr == EBR_REG_CFG) begin
      mode_q <= ebr_mode_e'(reg_wdata[EBR_CFG_MODE_LSB +: 2]);
      geom_a_q <= legal_geom(reg_wdata[EBR_CFG_GA_LSB +: 3],
                             reg_wdata[EBR_CFG_MODE_LSB +: 2]);
      geom_b_q <= legal_geom(reg_wdata[EBR_CFG_GB_LSB +: 3],
                             reg_wdata[EBR_CFG_MODE_LSB +: 2]);
      oreg_a_q <= reg_wdata[EBR_CFG_OREG_A];
      oreg_b_q <= reg_wdata[EBR_CFG_OREG_B];
    end
  end

  // Image load pointer: set directly, advanced by every data write.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ptr_q <= EBR_PTR_RST;
    end else if (ce && reg_wr) begin
      if (reg_addr == EBR_REG_INIT_ADDR) begin
        ptr_q <= reg_wdata[EBR_PTR_W-1:0];
      end else if (init_wr) begin
        ptr_q <= ptr_q + 9'h001;
      end
    end
  end

  // Sticky status flags; a new event in the clearing cycle keeps the flag set.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      coll_q <= 1'b0;
      romwr_q <= 1'b0;
    end else if (ce) begin
      coll_q <= coll_set ||
                (coll_q && !(reg_wr && reg_addr == EBR_REG_STATUS && reg_wdata[EBR_ST_COLL]));
      romwr_q <= romwr_set ||
                 (romwr_q && !(reg_wr && reg_addr == EBR_REG_STATUS && reg_wdata[EBR_ST_ROMWR]));
    end
  end

  // Read data stand for exactly the cycle after the read strobe.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata_q <= '0;
    end else if (ce) begin
      reg_rdata_q <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          EBR_REG_CFG: reg_rdata_q <= EBR_RDW'(cfg_word);
          EBR_REG_INIT_ADDR: reg_rdata_q <= EBR_RDW'(ptr_q);
          EBR_REG_INIT_DATA: reg_rdata_q <= EBR_RDW'(init_word);
          EBR_REG_STATUS: reg_rdata_q <= EBR_RDW'({romwr_q, coll_q});
          default: reg_rdata_q <= '0;
        endcase
      end
    end
  end

  assign reg_rdata = reg_rdata_q;

endmodule

// ==== verif/ebr_block_assertions.sv ====
// Port-level checks for the embedded block RAM, bound to its top module.
module ebr_block_assertions
  import ebr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [EBR_RAW-1:0] reg_addr,
  input wire logic [EBR_RDW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [EBR_RDW-1:0] reg_rdata,
  input wire logic a_addr_en,
  input wire logic a_we,
  input wire logic a_out_rst,
  input wire logic [EBR_DW-1:0] a_rdata,
  input wire logic b_addr_en,
  input wire logic b_we,
  input wire logic b_out_rst,
  input wire logic [EBR_DW-1:0] b_rdata
);
  ebr_mode_e mode_q;

  // A private copy of the mode field keeps the checks free of internal probes.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_q <= EBR_MODE_RST;
    end else if (ce && reg_wr && reg_addr == EBR_REG_CFG) begin
      mode_q <= ebr_mode_e'(reg_wdata[EBR_CFG_MODE_LSB +: 2]);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_REG_RDATA_IDLE: assert property (ce && !reg_rd |=> reg_rdata == '0)
    else $error("register read data not zero outside a read");
  AST_RESET_CLEARS: assert property (disable iff (1'b0)
    !rst_n && ce |=> a_rdata == '0 && b_rdata == '0 && reg_rdata == '0)
    else $error("reset left an output set");
  AST_A_OUT_RST: assert property (ce && a_out_rst |=> a_rdata == '0)
    else $error("port A output reset ignored");
  AST_A_ADDR_HOLD: assert property (
    (ce && !a_addr_en && !a_we && !b_we && !reg_wr && !a_out_rst)[*3] |=> $stable(a_rdata))
    else $error("port A read data moved with address held");
  AST_B_ADDR_HOLD: assert property (
    (ce && !b_addr_en && !a_we && !b_we && !reg_wr && !b_out_rst)[*3] |=> $stable(b_rdata))
    else $error("port B read data moved with address held");
  AST_SINGLE_B_ZERO: assert property ((ce && mode_q == EBR_SINGLE)[*3] |=> b_rdata == '0)
    else $error("port B not silent in single-port mode");
  AST_SDP_A_ZERO: assert property ((ce && mode_q == EBR_SIMPLE_DP)[*3] |=> a_rdata == '0)
    else $error("port A not silent in simple dual-port mode");
  AST_ROM_WR_FLAG: assert property ((ce && mode_q == EBR_ROM && a_we) ##1
    (ce && reg_rd && reg_addr == EBR_REG_STATUS) |=> reg_rdata[EBR_ST_ROMWR])
    else $error("write in read-only mode not flagged");
  AST_CE_FREEZE: assert property (
    !ce |=> $stable(a_rdata) && $stable(b_rdata) && $stable(reg_rdata))
    else $error("outputs moved while the clock enable was low");
endmodule

bind ebr_block ebr_block_assertions i_chk (
  .mclk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .a_addr_en, .a_we, .a_out_rst, .a_rdata, .b_addr_en, .b_we, .b_out_rst, .b_rdata
);

// ==== verif/ebr_fabric_user.sv ====
// Fabric logic model that reads the block through port B.
module ebr_fabric_user
  import ebr_pkg::*;
(
  input wire logic mclk,
  input wire logic [EBR_DW-1:0] b_rdata,
  output logic b_addr_en,
  output logic [EBR_AW-1:0] b_addr,
  output logic b_we,
  output logic [EBR_DW-1:0] b_wdata,
  output logic b_out_rst
);
  initial begin
    b_addr_en = 1'b0;
    b_addr = '0;
    b_we = 1'b0;
    b_wdata = '0;
    b_out_rst = 1'b0;
  end

  // Only locations already written are asked for, and the address is scrambled once released.
  task automatic rd(input logic [EBR_AW-1:0] a, output logic [EBR_DW-1:0] d);
    @(posedge mclk);
    b_addr_en <= 1'b1;
    b_addr <= a;
    @(posedge mclk);
    b_addr_en <= 1'b0;
    b_addr <= ~a;
    @(negedge mclk);
    d = b_rdata;
  endtask

  // Normal traffic never writes from this side; this is only for a deliberate collision test.
  task automatic wr(input logic [EBR_AW-1:0] a, input logic [EBR_DW-1:0] d);
    @(posedge mclk);
    b_addr_en <= 1'b1;
    b_addr <= a;
    b_we <= 1'b1;
    b_wdata <= d;
    @(posedge mclk);
    b_addr_en <= 1'b0;
    b_addr <= ~a;
    b_we <= 1'b0;
  endtask

  task automatic clr;
    @(posedge mclk);
    b_out_rst <= 1'b1;
    @(posedge mclk);
    b_out_rst <= 1'b0;
  endtask
endmodule

// ==== verif/ebr_block_tb.sv ====
// Self-checking testbench for the embedded block RAM.
module ebr_block_tb
  import ebr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, ce, reg_wr, reg_rd, a_addr_en, a_we, a_out_rst;
  logic b_addr_en, b_we, b_out_rst;
  logic [EBR_RAW-1:0] reg_addr;
  logic [EBR_RDW-1:0] reg_wdata, reg_rdata;
  logic [EBR_AW-1:0] a_addr, b_addr;
  logic [EBR_DW-1:0] a_wdata, a_rdata, b_wdata, b_rdata;
  logic [EBR_BEW-1:0] a_be;
  int n_errors = 0;
  int n_compared = 0;

  ebr_block i_dut (.mclk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .a_addr_en, .a_addr, .a_we, .a_wdata, .a_be, .a_out_rst, .a_rdata,
    .b_addr_en, .b_addr, .b_we, .b_wdata, .b_out_rst, .b_rdata);
  ebr_fabric_user i_fab (.mclk, .b_rdata, .b_addr_en, .b_addr, .b_we, .b_wdata, .b_out_rst);

  always #25 mclk = ~mclk;

  function automatic logic [31:0] cfg(input logic [1:0] m, input logic [2:0] ga,
                                      input logic [2:0] gb, input logic oa);
    return {22'h00_0000, 1'b0, oa, gb, ga, m};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("errors %0d, comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [EBR_RAW-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [EBR_RAW-1:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask

  task automatic pa(input logic [EBR_AW-1:0] a, input logic we, input logic [EBR_DW-1:0] wd,
                    input logic [EBR_BEW-1:0] be);
    @(posedge mclk);
    a_addr_en <= 1'b1;
    a_addr <= a;
    a_we <= we;
    a_wdata <= wd;
    a_be <= be;
    @(posedge mclk);
    a_addr_en <= 1'b0;
    a_addr <= ~a;
    a_we <= 1'b0;
    a_wdata <= ~wd;
  endtask

  task automatic s_rom;
    logic [31:0] d;
    wr(EBR_REG_CFG, cfg(EBR_ROM, 3'h0, 3'h0, 1'b0));
    wr(EBR_REG_INIT_ADDR, 32'h0000_0000);
    wr(EBR_REG_INIT_DATA, 32'h000A_5C3B);
    pa(13'h0001, 1'b0, 20'h0_0000, 2'h0);
    @(negedge mclk);
    chk("rom byte", 32'(a_rdata), 32'h0000_005C);
    // The status read must follow the refused write with no gap.
    @(posedge mclk);
    a_addr_en <= 1'b1;
    a_addr <= 13'h0001;
    a_we <= 1'b1;
    a_wdata <= 20'h0_00FF;
    @(posedge mclk);
    a_we <= 1'b0;
    reg_addr <= EBR_REG_STATUS;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk("rom write flag", reg_rdata, 32'h0000_0002);
    wr(EBR_REG_INIT_ADDR, 32'h0000_0000);
    rd(EBR_REG_INIT_DATA, d);
    chk("image readback", d, 32'h000A_5C3B);
    rd(4'h2, d);
    chk("unmapped read", d, 32'h0000_0000);
  endtask

  task automatic s_tdp;
    int w;
    logic [19:0] p, d;
    int wt[6] = '{8, 4, 2, 1, 10, 5};
    int dp[6] = '{1024, 2048, 4096, 8192, 1024, 2048};
    for (int g = 0; g < 6; g++) begin
      w = wt[g];
      p = 20'h5_5355 & ((20'h0_0001 << w) - 20'h0_0001);
      wr(EBR_REG_CFG, cfg(EBR_TRUE_DP, 3'(g), 3'(g), 1'b0));
      pa(13'h0003, 1'b1, p, 2'h0);
      i_fab.rd(13'(3 + dp[g]), d);
      chk("tdp word", 32'(d), 32'(p));
      wr(EBR_REG_CFG, cfg(EBR_TRUE_DP, 3'(g), 3'h3, 1'b0));
      i_fab.rd(13'(4 * w - 1), d);
      chk("tdp mixed width", 32'(d), 32'((p >> (w - 1)) & 20'h0_0001));
    end
  endtask

  task automatic s_sdp;
    logic [19:0] d;
    logic [19:0] d1[2] = '{20'hF_FFFF, 20'h0_1234};
    logic [19:0] d2[2] = '{20'h0_0000, 20'h0_ABCD};
    logic [1:0] b2[2] = '{2'h1, 2'h2};
    logic [19:0] ex[2] = '{20'hF_FC00, 20'h0_AB34};
    for (int k = 0; k < 2; k++) begin
      wr(EBR_REG_CFG, cfg(EBR_SIMPLE_DP, 3'(7 - k), 3'(7 - k), 1'b0));
      pa(13'h0005, 1'b1, d1[k], 2'h3);
      pa(13'h0005, 1'b1, d2[k], b2[k]);
      i_fab.rd(13'h0005, d);
      chk("sdp lanes", 32'(d), 32'(ex[k]));
    end
  endtask

  task automatic s_hold;
    logic [19:0] d;
    wr(EBR_REG_CFG, cfg(EBR_TRUE_DP, 3'h0, 3'h0, 1'b1));
    pa(13'h0008, 1'b1, 20'h0_00C3, 2'h0);
    pa(13'h0007, 1'b1, 20'h0_005A, 2'h0);
    i_fab.rd(13'h0007, d);
    chk("cross port", 32'(d), 32'h0000_005A);
    chk("held address", 32'(a_rdata), 32'h0000_005A);
    @(posedge mclk);
    a_out_rst <= 1'b1;
    @(posedge mclk);
    a_out_rst <= 1'b0;
    @(negedge mclk);
    chk("output reset", 32'(a_rdata), 32'h0000_0000);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("array kept", 32'(a_rdata), 32'h0000_005A);
  endtask

  // Every word is loaded first, so no read and no assertion ever meets an undefined cell.
  task automatic s_load;
    logic [31:0] d;
    for (int i = 0; i < 511; i++) begin
      wr(EBR_REG_INIT_DATA, 32'h0000_0000);
    end
    rd(EBR_REG_INIT_ADDR, d);
    chk("pointer advance", d, 32'h0000_01FF);
    wr(EBR_REG_INIT_DATA, 32'h0000_0000);
    rd(EBR_REG_INIT_ADDR, d);
    chk("pointer wrap", d, 32'h0000_0000);
  endtask

  task automatic s_freeze;
    logic [31:0] d;
    wr(EBR_REG_CFG, cfg(EBR_TRUE_DP, 3'h0, 3'h0, 1'b0) | (32'h0000_0001 << EBR_CFG_OREG_B));
    // Both ports hit one cell on purpose, to see the collision flag and port B prevail.
    fork
      pa(13'h0009, 1'b1, 20'h0_0011, 2'h0);
      i_fab.wr(13'h0009, 20'h0_0022);
    join
    rd(EBR_REG_STATUS, d);
    chk("status flags", d, 32'h0000_0003);
    wr(EBR_REG_STATUS, 32'h0000_0003);
    rd(EBR_REG_STATUS, d);
    chk("status cleared", d, 32'h0000_0000);
    chk("shared cell", 32'(b_rdata), 32'h0000_0022);
    i_fab.clr();
    @(negedge mclk);
    chk("port b output reset", 32'(b_rdata), 32'h0000_0000);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("port b array kept", 32'(b_rdata), 32'h0000_0022);
    // A read and an address capture tried while the clock enable is low must both be lost.
    @(posedge mclk);
    ce <= 1'b0;
    a_addr_en <= 1'b1;
    a_addr <= 13'h0007;
    reg_addr <= EBR_REG_CFG;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk("frozen port", 32'(a_rdata), 32'h0000_0022);
    chk("frozen bus", reg_rdata, 32'h0000_0000);
    @(posedge mclk);
    ce <= 1'b1;
    a_addr_en <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk("capture frozen", 32'(a_rdata), 32'h0000_0022);
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk("reset port a", 32'(a_rdata), 32'h0000_0000);
    rd(EBR_REG_CFG, d);
    chk("reset config", d, 32'h0000_0000);
    pa(13'h0009, 1'b0, 20'h0_0000, 2'h0);
    @(negedge mclk);
    chk("array survives reset", 32'(a_rdata), 32'h0000_0022);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    complete_run();
  end

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    a_addr_en = 1'b0;
    a_addr = '0;
    a_we = 1'b0;
    a_wdata = '0;
    a_be = '0;
    a_out_rst = 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    s_load();
    s_rom();
    s_tdp();
    s_sdp();
    s_hold();
    s_freeze();
    complete_run();
  end
endmodule
